// [core/eeprom_word_reader.sv]
/*
 * Reads one 16-bit word from a microwire serial EEPROM.
 * Assumes the caller holds start until busy rises is not needed: start is a one-cycle pulse.
 */
`timescale 1ns/100ps
module eeprom_word_reader (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic [5:0] addr_i,
   input wire logic ee_do_i,
   output logic ee_cs_o,
   output logic ee_sk_o,
   output logic ee_di_o,
   output logic busy_o,
   output logic done_o,
   output logic [15:0] word_o
);
   import pm_cfg_pkg::*;

   logic [3:0] div_r;
   logic [4:0] slot_r;
   logic [8:0] cmd_r;

   // One frame: start bit, read opcode, address, dummy zero, sixteen data bits.
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         div_r <= 4'h0;
         slot_r <= 5'h00;
         cmd_r <= 9'h000;
         ee_cs_o <= 1'b0;
         ee_sk_o <= 1'b0;
         ee_di_o <= 1'b0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
         word_o <= 16'h0000;
      end else begin
         done_o <= 1'b0;
         if (!busy_o) begin
            if (start_i) begin
               busy_o <= 1'b1;
               ee_cs_o <= 1'b1;
               ee_di_o <= EE_READ_OP[2];
               cmd_r <= {EE_READ_OP[1:0], addr_i, 1'b0};
               slot_r <= 5'h00;
               div_r <= 4'h0;
            end
         end else if (div_r == 4'(EE_HALF_CYCLES - 1)) begin
            div_r <= 4'h0;
            if (!ee_sk_o) begin
               ee_sk_o <= 1'b1; // The EEPROM takes DI on this rising edge.
            end else begin
               ee_sk_o <= 1'b0;
               // Data out is stable late in the high phase.
               if (slot_r >= EE_FIRST_DATA_SLOT) begin
                  word_o <= {word_o[14:0], ee_do_i};
               end
               if (slot_r == EE_LAST_SLOT) begin
                  busy_o <= 1'b0;
                  ee_cs_o <= 1'b0;
                  ee_di_o <= 1'b0;
                  done_o <= 1'b1;
               end else begin
                  slot_r <= slot_r + 5'd1;
                  ee_di_o <= cmd_r[8];
                  cmd_r <= {cmd_r[7:0], 1'b0};
               end
            end
         end else begin
            div_r <= div_r + 4'h1;
         end
      end
   end
endmodule

// [core/pci_power_mgmt_config_preload.sv]
/*
 * Power-management capability, wake-event logic, user information dword and the
 * EEPROM preload of identity fields for a four-channel serial controller.
 * Assumes a PCI target core that decodes configuration cycles into cfg_rd_i and
 * cfg_wr_i pulses and reports memory-space hits on mem_req_i.
 */
`timescale 1ns/100ps
module pci_power_mgmt_config_preload #(
   parameter logic [15:0] VENDOR_RESET = 16'h1234, // Arbitrary value.
   parameter logic [15:0] DEVICE_RESET = 16'h5678, // Arbitrary value.
   parameter logic [7:0] REVISION_ID = 8'h01, // Arbitrary value.
   parameter int LOAD_LIMIT = pm_cfg_pkg::LOAD_LIMIT_CLOCKS
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic cfg_rd_i,
   input wire logic cfg_wr_i,
   input wire logic [7:0] cfg_addr_i,
   input wire logic [31:0] cfg_wdata_i,
   input wire logic [3:0] cfg_be_i,
   output logic [31:0] cfg_rdata_o,
   output logic cfg_ack_o,
   input wire logic cmd_mem_en_i,
   input wire logic mem_req_i,
   output logic mem_accept_o,
   input wire logic uart_irq_i,
   output logic inta_n_o,
   output logic pme_n_o,
   output logic pci_drv_en_o,
   output logic d0_active_o,
   input wire logic [3:0] rx_i,
   input wire logic [15:0] modem_status_delta_i,
   output logic [3:0] rx_to_uart_o,
   input wire logic eeprom_chip_select_i,
   output logic eeprom_chip_select_o,
   output logic eeprom_chip_select_oe_o,
   output logic ee_sk_o,
   output logic ee_di_o,
   input wire logic ee_do_i,
   output logic load_busy_o
);
   import pm_cfg_pkg::*;

   typedef enum logic [3:0] {
      ST_D0_UNINIT = 4'b0001,
      ST_D0_ACTIVE = 4'b0010,
      ST_D3_HOT = 4'b0100,
      ST_D3_EXIT = 4'b1000
   } pm_state_t;

   pm_state_t state_r;
   pm_state_t state_nxt;
   logic [7:0] exit_cnt_r;
   logic [1:0] pstate_r;
   logic pme_en_r;
   logic pme_status_r;
   logic pme_status_nxt;
   logic [3:0] rx_prev_r;
   logic [15:0] delta_prev_r;
   logic wake_event;
   logic csr_wr;
   logic [15:0] vendor_r;
   logic [15:0] device_r;
   logic [23:0] class_r;
   logic [15:0] subsys_vendor_r;
   logic [15:0] subsys_id_r;
   logic [31:0] user_r;
   logic strap_pending_r;
   logic ld_start_r;
   logic [2:0] ld_idx_r;
   logic [16:0] ld_cnt_r;
   logic rd_done;
   logic [15:0] rd_word;
   logic rd_cs;

   // Builds the capabilities dword from its fixed fields.
   function automatic logic [31:0] cap_word();
      cap_word = {CAP_EVENT_SUPPORT, CAP_RESERVED, CAP_CLOCK_NEEDED, CAP_VERSION,
                  CAP_NEXT_PTR, CAP_ID};
   endfunction

   // Builds the control/status dword; unimplemented and reserved bits read zero.
   function automatic logic [31:0] csr_word(input logic st, input logic en,
                                            input logic [1:0] ps);
      csr_word = {16'h0000, st, 6'h00, en, 6'h00, ps};
   endfunction

   assign csr_wr = cfg_wr_i && (cfg_addr_i == OFS_PM_CSR);

   // Wake events: a start bit or a modem delta flag rising on any channel.
   assign wake_event = (|(rx_prev_r & ~rx_i))
                       || (|(modem_status_delta_i & ~delta_prev_r));

   // Edge history for the event detectors; receivers are never gated.
   // History resets to the idle high level, so reset release never looks like a start bit.
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         rx_prev_r <= 4'hF;
         delta_prev_r <= 16'h0000;
         rx_to_uart_o <= 4'hF;
      end else begin
         rx_prev_r <= rx_i;
         delta_prev_r <= modem_status_delta_i;
         rx_to_uart_o <= rx_i;
      end
   end

   // Next power state from software writes of the state field.
   // Leaving D3hot passes through a drivers-off stretch before D0 uninitialized.
   // Codes 01 and 10 match no branch, so such writes leave the state alone.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_D0_UNINIT: begin
            if (csr_wr && cfg_be_i[0] && cfg_wdata_i[1:0] == PSTATE_D3HOT) begin
               state_nxt = ST_D3_HOT;
            end else if (cmd_mem_en_i) begin
               state_nxt = ST_D0_ACTIVE;
            end
         end
         ST_D0_ACTIVE: begin
            if (csr_wr && cfg_be_i[0] && cfg_wdata_i[1:0] == PSTATE_D3HOT) begin
               state_nxt = ST_D3_HOT;
            end
         end
         ST_D3_HOT: begin
            if (csr_wr && cfg_be_i[0] && cfg_wdata_i[1:0] == PSTATE_D0) begin
               state_nxt = ST_D3_EXIT;
            end
         end
         ST_D3_EXIT: begin
            if (exit_cnt_r == 8'(D3_EXIT_CYCLES - 1)) begin
               state_nxt = ST_D0_UNINIT;
            end
         end
         default: begin
            state_nxt = ST_D0_UNINIT;
         end
      endcase
   end

   // State register and the drivers-off counter for leaving D3hot.
   // The counter runs only in the exit state and is back at zero for the next exit.
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state_r <= ST_D0_UNINIT;
         exit_cnt_r <= 8'h00;
      end else begin
         state_r <= state_nxt;
         if (state_r == ST_D3_EXIT) begin
            exit_cnt_r <= exit_cnt_r + 8'h01;
         end else begin
            exit_cnt_r <= 8'h00;
         end
      end
   end

   // Visible state field follows the machine; only 00 and 11 are ever held.
   // Reading the field during the drivers-off stretch already shows D0.
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         pstate_r <= PSTATE_D0;
      end else if (state_nxt == ST_D3_HOT) begin
         pstate_r <= PSTATE_D3HOT;
      end else begin
         pstate_r <= PSTATE_D0;
      end
   end

   // Event enable is plain read/write; it survives D3hot exit untouched.
   // The enable of byte one guards both the event enable and the status clear.
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         pme_en_r <= 1'b0;
      end else if (csr_wr && cfg_be_i[1]) begin
         pme_en_r <= cfg_wdata_i[CSR_ENABLE_BIT];
      end
   end

   // Event status: a new event wins over a write-one clear in the same cycle.
   // Events outside D3hot are not counted, so normal traffic leaves no stale status.
   // Letting the set win means an event is never lost to a clear that crosses it.
   always_comb begin
      pme_status_nxt = pme_status_r;
      if (csr_wr && cfg_be_i[1] && cfg_wdata_i[CSR_STATUS_BIT]) begin
         pme_status_nxt = 1'b0;
      end
      if (wake_event && state_r == ST_D3_HOT) begin
         pme_status_nxt = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         pme_status_r <= 1'b0;
      end else begin
         pme_status_r <= pme_status_nxt;
      end
   end

   // Wake output is active low and held while status and enable are both set in D3hot.
   // Next-state values let the output fall on the same edge that sets the status.
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         pme_n_o <= 1'b1;
      end else begin
         pme_n_o <= ~(pme_status_nxt && pme_en_r && state_nxt == ST_D3_HOT);
      end
   end

   // Bus-facing gating by power state.
   // Memory hits and interrupts are dropped unless the function is in D0 active.
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         pci_drv_en_o <= 1'b0;
         mem_accept_o <= 1'b0;
         inta_n_o <= 1'b1;
         d0_active_o <= 1'b0;
      end else begin
         pci_drv_en_o <= (state_nxt != ST_D3_EXIT);
         mem_accept_o <= mem_req_i && state_r == ST_D0_ACTIVE;
         inta_n_o <= ~(uart_irq_i && state_r == ST_D0_ACTIVE);
         d0_active_o <= (state_nxt == ST_D0_ACTIVE);
      end
   end

   // Configuration reads answer in every state, one cycle after the request.
   // Read data is zero whenever no read is answered, so it can be ORed onto a shared bus.
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         cfg_ack_o <= 1'b0;
         cfg_rdata_o <= 32'h00000000;
      end else begin
         cfg_ack_o <= cfg_rd_i || cfg_wr_i;
         if (cfg_rd_i) begin
            case (cfg_addr_i)
               OFS_ID: cfg_rdata_o <= {device_r, vendor_r};
               OFS_CLASS: cfg_rdata_o <= {class_r, REVISION_ID};
               OFS_SUBSYS: cfg_rdata_o <= {subsys_id_r, subsys_vendor_r};
               OFS_CAP_PTR: cfg_rdata_o <= {24'h000000, CAP_POINTER};
               OFS_PM_CAP: cfg_rdata_o <= cap_word();
               OFS_PM_CSR: cfg_rdata_o <= csr_word(pme_status_r, pme_en_r, pstate_r);
               OFS_USER: cfg_rdata_o <= user_r;
               default: cfg_rdata_o <= 32'h00000000;
            endcase
         end else begin
            cfg_rdata_o <= 32'h00000000;
         end
      end
   end

   // Chip-select strap is caught on the first edge after reset release.
   // The output enable stays low through reset so the pulled level on the pin can be read.
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         strap_pending_r <= 1'b1;
         eeprom_chip_select_oe_o <= 1'b0;
      end else if (strap_pending_r) begin
         strap_pending_r <= 1'b0;
         eeprom_chip_select_oe_o <= 1'b1;
      end
   end

   // Chip select drives the pin once the strap has been read.
   // This costs one clock of chip-select delay, which the slow serial clock hides.
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         eeprom_chip_select_o <= 1'b0;
      end else begin
         eeprom_chip_select_o <= rd_cs;
      end
   end

   // Preload sequencer: eight words read one after another, bounded by a watchdog.
   // The watchdog counts from reset release and ends the load just short of the limit,
   // so a missing or silent EEPROM cannot keep the load flag up for ever.
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         load_busy_o <= 1'b0;
         ld_start_r <= 1'b0;
         ld_idx_r <= 3'h0;
         ld_cnt_r <= 17'h00000;
      end else begin
         ld_start_r <= 1'b0;
         if (ld_cnt_r != 17'h1FFFF) begin
            ld_cnt_r <= ld_cnt_r + 17'h00001;
         end
         if (strap_pending_r && eeprom_chip_select_i) begin
            load_busy_o <= 1'b1;
            ld_start_r <= 1'b1;
            ld_idx_r <= 3'h0;
         end else if (load_busy_o && ld_cnt_r >= 17'(LOAD_LIMIT - 2)) begin
            load_busy_o <= 1'b0;
         end else if (load_busy_o && rd_done) begin
            if (ld_idx_r == EE_LAST_WORD) begin
               load_busy_o <= 1'b0;
            end else begin
               ld_idx_r <= ld_idx_r + 3'h1;
               ld_start_r <= 1'b1;
            end
         end
      end
   end

   // Loaded fields; the revision byte is never touched by the load.
   // A word that never arrives leaves its field at the reset value.
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         vendor_r <= VENDOR_RESET;
         device_r <= DEVICE_RESET;
         class_r <= CLASS_RESET;
         subsys_vendor_r <= SUBSYS_RESET;
         subsys_id_r <= SUBSYS_RESET;
         user_r <= USER_RESET;
      end else if (load_busy_o && rd_done) begin
         case (ld_idx_r)
            3'h0: vendor_r <= rd_word;
            3'h1: device_r <= rd_word;
            3'h2: class_r[7:0] <= rd_word[15:8];
            3'h3: class_r[23:8] <= rd_word;
            3'h4: subsys_vendor_r <= rd_word;
            3'h5: subsys_id_r <= rd_word;
            3'h6: user_r[15:0] <= rd_word;
            3'h7: user_r[31:16] <= rd_word;
            default: user_r <= user_r;
         endcase
      end
   end

   // Serial word reader for the microwire EEPROM.
   // Its busy flag is not needed here, as the done pulse alone paces the sequencer.
   eeprom_word_reader u_reader (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .start_i(ld_start_r),
      .addr_i({3'b000, ld_idx_r}),
      .ee_do_i(ee_do_i),
      .ee_cs_o(rd_cs),
      .ee_sk_o(ee_sk_o),
      .ee_di_o(ee_di_o),
      .busy_o(),
      .done_o(rd_done),
      .word_o(rd_word)
   );
endmodule

// [core/pm_cfg_pkg.sv]
/*
 * Constants for the power-management and configuration-preload block.
 * Assumes a single 20 MHz system clock and configuration offsets given as byte addresses.
 */
// How it works
// - Power registers sit as two dwords starting at configuration offset 40h.
// - Capabilities dword is read-only: D3hot events, clock needed, version 2, ID 01h.
// - In D3hot with event enable set, the wake output is asserted on a wake event.
// - A falling receive input on any channel is a wake event.
// - Any modem delta flag rising on any channel is a wake event.
// - In D3hot, event status is set on a wake event whatever the enable bit says.
// - Event status is cleared by writing one; it resets to zero.
// - Power state and event enable are read/write; reserved bits read zero.
// - Entering D0 from reset or D3hot lands in D0 uninitialized first.
// - D0 active accepts all transactions and may raise the interrupt.
// - D3hot answers only configuration accesses; memory and interrupts are blocked.
// - Receivers and flow control keep running in D3hot.
// - Leaving D3hot for D0 keeps every register value.
// - Bus drivers stay disabled through the D3hot to D0 transition.
// - Reset returns every register and output to its power-on value.
// - User information dword at 48h resets to zero, loads only from EEPROM.
// - The EEPROM is a serial microwire part with 16-bit words.
// - The download runs only if the chip-select pin is high at reset release.
// - The download finishes within 2^16 clocks of reset release.
// - EEPROM words 0 to 7 load identity, class, subsystem and user fields in order.
// - Only the upper byte of the first class word is used.
// - The capability pointer reads 40h.
package pm_cfg_pkg;
   // Configuration offsets.
   localparam logic [7:0] OFS_ID = 8'h00;
   localparam logic [7:0] OFS_CLASS = 8'h08;
   localparam logic [7:0] OFS_SUBSYS = 8'h2C;
   localparam logic [7:0] OFS_CAP_PTR = 8'h34;
   localparam logic [7:0] OFS_PM_CAP = 8'h40;
   localparam logic [7:0] OFS_PM_CSR = 8'h44;
   localparam logic [7:0] OFS_USER = 8'h48;
   // Capabilities dword fields.
   localparam logic [4:0] CAP_EVENT_SUPPORT = 5'b01000;
   localparam logic [6:0] CAP_RESERVED = 7'h00;
   localparam logic CAP_CLOCK_NEEDED = 1'b1;
   localparam logic [2:0] CAP_VERSION = 3'b010;
   localparam logic [7:0] CAP_NEXT_PTR = 8'h00;
   localparam logic [7:0] CAP_ID = 8'h01;
   localparam logic [7:0] CAP_POINTER = 8'h40;
   // Control/status field positions.
   localparam int CSR_STATUS_BIT = 15;
   localparam int CSR_ENABLE_BIT = 8;
   localparam logic [1:0] PSTATE_D0 = 2'b00;
   localparam logic [1:0] PSTATE_D3HOT = 2'b11;
   // Reset values of loadable fields.
   localparam logic [23:0] CLASS_RESET = 24'h070002;
   localparam logic [15:0] SUBSYS_RESET = 16'h0000;
   localparam logic [31:0] USER_RESET = 32'h00000000;
   // EEPROM layout and timing.
   localparam logic [2:0] EE_LAST_WORD = 3'h7;
   localparam logic [2:0] EE_READ_OP = 3'b110;
   localparam int EE_SK_MAX_KHZ = 1250;
   localparam int SYS_CLK_KHZ = 20000;
   localparam int EE_HALF_CYCLES = (SYS_CLK_KHZ + 2 * EE_SK_MAX_KHZ - 1) / (2 * EE_SK_MAX_KHZ);
   localparam logic [4:0] EE_FIRST_DATA_SLOT = 5'd9;
   localparam logic [4:0] EE_LAST_SLOT = 5'd24;
   localparam int LOAD_LIMIT_CLOCKS = 65536;
   // Time that bus drivers stay off while leaving D3hot, in ns.
   localparam int D3_EXIT_NS = 200;
   localparam int D3_EXIT_CYCLES = (D3_EXIT_NS * SYS_CLK_KHZ + 999999) / 1000000;
endpackage

// [testbench/eeprom_model.sv]
/* Behavioural serial EEPROM with eight 16-bit words given on a port.
   Assumes the reader sends start, opcode and six address bits per frame. */
`timescale 1ns/100ps
module eeprom_model (
   input wire logic cs_i,
   input wire logic sk_i,
   input wire logic di_i,
   input wire logic [127:0] words_i,
   output logic do_o
);
   logic [4:0] slot_r = 5'h00;
   logic [5:0] addr_r = 6'h00;
   logic do_r = 1'b0;
   logic drive_r = 1'b0;
   // Shifts the address in, then a dummy zero and the word out, MSB first.
   always_ff @(posedge sk_i or negedge cs_i) begin
      if (!cs_i) begin
         slot_r <= 5'h00;
         drive_r <= 1'b0;
      end else begin
         slot_r <= slot_r + 5'h01;
         if (slot_r >= 5'h03 && slot_r <= 5'h08) addr_r <= {addr_r[4:0], di_i};
         drive_r <= (slot_r >= 5'h08);
         if (slot_r >= 5'h08) begin
            do_r <= (slot_r == 5'h08) ? 1'b0 : words_i[addr_r[2:0] * 16 + 24 - slot_r];
         end
      end
   end
   // A released line shows the inverse of its last level.
   assign do_o = drive_r ? do_r : ~do_r;
endmodule

// [testbench/pci_power_mgmt_config_preload_test.sv]
/* Self-checking bench for the power-management and preload block.
   Assumes the package, the block and the EEPROM model are compiled first. */
`timescale 1ns/100ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin num_errors++; \
   $display("mismatch at %0t: got %0h expected %0h", $time, (a), (e)); end end
module pci_power_mgmt_config_preload_test;
   import pm_cfg_pkg::*;
   localparam logic [15:0] VEN = 16'h1234; // Arbitrary value.
   localparam logic [15:0] DEV = 16'h5678; // Arbitrary value.
   logic sys_clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, cmd = 1'b0, mreq = 1'b0;
   logic irq = 1'b0, strap = 1'b1, ld = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h00000000, q, seed = 32'h00011D91, rdata;
   logic [3:0] be = 4'hF, rx = 4'hF, rx_u;
   logic [15:0] delta = 16'h0000, csr = 16'h0000;
   logic [15:0] w [0:7];
   logic ack, accept, inta_n, pme_n, drv_en, d0, cs_o, cs_oe, sk, di, do_w, busy, cs_pin;
   int num_errors = 0, check_count = 0;
   // The strap pin is pulled to the bench's level while the block does not drive it.
   assign cs_pin = cs_oe ? cs_o : strap;
   pci_power_mgmt_config_preload #(.VENDOR_RESET(VEN), .DEVICE_RESET(DEV),
      .REVISION_ID(8'h01), .LOAD_LIMIT(20000)) dut (.sys_clk_i(sys_clk), .rst_i(rst),
      .cfg_rd_i(rd), .cfg_wr_i(wr), .cfg_addr_i(addr), .cfg_wdata_i(wdata),
      .cfg_be_i(be), .cfg_rdata_o(rdata), .cfg_ack_o(ack), .cmd_mem_en_i(cmd),
      .mem_req_i(mreq), .mem_accept_o(accept), .uart_irq_i(irq), .inta_n_o(inta_n),
      .pme_n_o(pme_n), .pci_drv_en_o(drv_en), .d0_active_o(d0), .rx_i(rx),
      .modem_status_delta_i(delta), .rx_to_uart_o(rx_u), .eeprom_chip_select_i(cs_pin),
      .eeprom_chip_select_o(cs_o), .eeprom_chip_select_oe_o(cs_oe), .ee_sk_o(sk),
      .ee_di_o(di), .ee_do_i(do_w), .load_busy_o(busy));
   eeprom_model ee (.cs_i(cs_pin), .sk_i(sk), .di_i(di), .do_o(do_w),
      .words_i({w[7], w[6], w[5], w[4], w[3], w[2], w[1], w[0]}));
   // Free-running 20 MHz clock.
   always #25 sys_clk = ~sys_clk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
   endfunction
   // Expected configuration read value from the loaded words and the modelled state.
   function automatic logic [31:0] exp_rd(input logic [7:0] a);
      case (a)
         OFS_ID: return ld ? {w[1], w[0]} : {DEV, VEN};
         OFS_CLASS: return {ld ? {w[3], w[2][15:8]} : CLASS_RESET, 8'h01};
         OFS_SUBSYS: return ld ? {w[5], w[4]} : 32'h00000000;
         OFS_CAP_PTR: return 32'h00000040;
         OFS_PM_CAP: return 32'h400A0001;
         OFS_PM_CSR: return {16'h0000, csr};
         OFS_USER: return ld ? {w[7], w[6]} : 32'h00000000;
         default: return 32'h00000000;
      endcase
   endfunction
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic acc(input logic wen, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      rd <= !wen;
      wr <= wen;
      addr <= a;
      wdata <= d;
      @(posedge sys_clk);
      rd <= 1'b0;
      wr <= 1'b0;
      #1;
      q = rdata;
      `CHK(ack, 1'b1)
   endtask
   task automatic chk_map();
      logic [7:0] al [9] = '{8'h00, 8'h08, 8'h2C, 8'h34, 8'h40, 8'h44, 8'h48, 8'h4C, 8'hFC};
      foreach (al[i]) begin
         acc(1'b0, al[i], 32'h00000000);
         `CHK(q, exp_rd(al[i]))
      end
   endtask
   task automatic wait_for(ref logic sig, input logic lvl, input int lim);
      for (int i = 0; i < lim && sig !== lvl; i++) @(posedge sys_clk);
      #1;
      if (sig !== lvl) begin
         num_errors++;
         $display("timeout at %0t", $time);
         end_sim();
      end
   endtask
   task automatic reset_dut(input logic s);
      @(posedge sys_clk);
      rst <= 1'b1;
      strap <= s;
      cmd <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      #1;
      `CHK(busy, s)
      ld = s;
      csr = 16'h0000;
      wait_for(busy, 1'b0, 4000);
   endtask
   // One wake event, a falling receive input or a rising delta flag.
   task automatic ev(input logic is_rx, input logic [3:0] ch);
      @(posedge sys_clk);
      if (is_rx) rx[ch[1:0]] <= 1'b0;
      else delta[ch] <= 1'b1;
      @(posedge sys_clk);
      rx <= 4'hF;
      delta <= 16'h0000;
      #1;
      if (csr[1:0] == PSTATE_D3HOT) csr[15] = 1'b1;
      `CHK(pme_n, !(csr[15] && csr[8]))
      `CHK(rx_u, is_rx ? ~(4'h1 << ch[1:0]) : 4'hF)
   endtask
   initial begin
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         w[i] = seed[15:0];
      end
      reset_dut(1'b1);
      chk_map();
      seed = lfsr(seed);
      acc(1'b1, OFS_PM_CAP, seed);
      acc(1'b1, OFS_USER, seed);
      chk_map();
      $display("test preload done");
      @(posedge sys_clk);
      cmd <= 1'b1;
      irq <= 1'b1;
      mreq <= 1'b1;
      repeat (2) @(posedge sys_clk);
      #1;
      `CHK({d0, accept, inta_n}, 3'b110)
      acc(1'b1, OFS_PM_CSR, 32'h00000001);
      acc(1'b1, OFS_PM_CSR, 32'h00000002);
      be <= 4'hE;
      acc(1'b1, OFS_PM_CSR, 32'h00000003);
      be <= 4'hF;
      chk_map();
      acc(1'b1, OFS_PM_CSR, 32'hFFFF7FFF);
      csr = 16'h0103;
      chk_map();
      cmd <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      `CHK({accept, inta_n}, 2'b01)
      $display("test d3hot entry done");
      seed = lfsr(seed);
      ev(1'b1, seed[3:0]);
      chk_map();
      acc(1'b1, OFS_PM_CSR, 32'h00008103);
      csr = 16'h0103;
      @(posedge sys_clk);
      #1;
      `CHK(pme_n, 1'b1)
      ev(1'b0, seed[7:4]);
      acc(1'b1, OFS_PM_CSR, 32'h00008003);
      csr = 16'h0003;
      ev(1'b1, seed[9:8]);
      chk_map();
      $display("test wake done");
      acc(1'b1, OFS_PM_CSR, 32'h00008000);
      csr = 16'h0000;
      `CHK(drv_en, 1'b0)
      wait_for(drv_en, 1'b1, 10);
      `CHK(d0, 1'b0)
      ev(1'b1, seed[11:8]);
      chk_map();
      @(posedge sys_clk);
      cmd <= 1'b1;
      repeat (2) @(posedge sys_clk);
      #1;
      `CHK({d0, accept, inta_n}, 3'b110)
      $display("test d3hot exit done");
      reset_dut(1'b0);
      chk_map();
      `CHK({d0, pme_n}, 2'b01)
      $display("test reset without preload done");
      end_sim();
   end
endmodule

// [testbench/pm_preload_chk.sv]
/* Concurrent checks on the power-management and preload block's ports.
   Assumes one clock domain and a synchronous active-high reset. */
`timescale 1ns/100ps
module pm_preload_chk #(
   parameter int LOAD_LIMIT = 65536
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic cfg_rd_i,
   input wire logic cfg_wr_i,
   input wire logic [7:0] cfg_addr_i,
   input wire logic [31:0] cfg_wdata_i,
   input wire logic [3:0] cfg_be_i,
   input wire logic [31:0] cfg_rdata_o,
   input wire logic cfg_ack_o,
   input wire logic uart_irq_i,
   input wire logic inta_n_o,
   input wire logic pme_n_o,
   input wire logic pci_drv_en_o,
   input wire logic [3:0] rx_i,
   input wire logic [15:0] modem_status_delta_i,
   input wire logic [3:0] rx_to_uart_o,
   input wire logic eeprom_chip_select_i,
   input wire logic load_busy_o
);
   logic [16:0] busy_cnt_r;
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);
   // Counts the clocks of one preload so its length can be bounded.
   always_ff @(posedge sys_clk_i) begin
      busy_cnt_r <= (rst_i || !load_busy_o) ? 17'h00000 : busy_cnt_r + 17'h00001;
   end
   ack_delay_a: assert property ((cfg_rd_i || cfg_wr_i) |=> cfg_ack_o)
      else $error("config access not acknowledged");
   cap_value_a: assert property (cfg_rd_i && cfg_addr_i == 8'h40 |=>
      cfg_rdata_o == 32'h400A0001) else $error("capabilities word wrong");
   irq_gate_a: assert property (!inta_n_o |-> $past(uart_irq_i))
      else $error("interrupt without cause");
   rx_pass_a: assert property (!$past(rst_i) |-> rx_to_uart_o == $past(rx_i))
      else $error("receive path gated");
   wake_cause_a: assert property ($fell(pme_n_o) |-> $past(cfg_wr_i)
      || |($past(rx_i, 2) & ~$past(rx_i))
      || |($past(modem_status_delta_i) & ~$past(modem_status_delta_i, 2)))
      else $error("wake output without event");
   wake_release_a: assert property (cfg_wr_i && cfg_addr_i == 8'h44 && cfg_be_i[1]
      && !cfg_wdata_i[8] |-> ##[1:2] pme_n_o) else $error("wake not released");
   driver_exit_a: assert property ($fell(pci_drv_en_o) && !$past(rst_i) |->
      !pci_drv_en_o [*4] ##[1:2] pci_drv_en_o) else $error("driver off time wrong");
   strap_load_a: assert property (!$past(rst_i) && $past(rst_i, 2) |->
      load_busy_o == $past(eeprom_chip_select_i)) else $error("strap ignored");
   load_bound_a: assert property (busy_cnt_r < LOAD_LIMIT)
      else $error("preload too long");
   cover property ($fell(pme_n_o));
   cover property ($rose(pci_drv_en_o));
   cover property ($fell(load_busy_o));
endmodule
bind pci_power_mgmt_config_preload pm_preload_chk #(.LOAD_LIMIT(LOAD_LIMIT)) chk (
   .sys_clk_i, .rst_i, .cfg_rd_i, .cfg_wr_i, .cfg_addr_i, .cfg_wdata_i, .cfg_be_i,
   .cfg_rdata_o, .cfg_ack_o, .uart_irq_i, .inta_n_o, .pme_n_o, .pci_drv_en_o, .rx_i,
   .modem_status_delta_i, .rx_to_uart_o, .eeprom_chip_select_i, .load_busy_o);
